// file: logic/ifag_pkg.sv
package ifag_pkg;
    // ----------------------------------------------------------------
    // Word layout (word bit n, counted from the sign, is vector bit 35-n)
    // ----------------------------------------------------------------
    localparam int WORD_W = 36;
    localparam int ADR_W = 15;
    localparam int OP_MSB = 35;
    localparam int OP_LSB = 24;
    localparam int MOD_MSB = 23;
    localparam int MOD_LSB = 15;
    localparam int ADR_MSB = 14;
    localparam int ADR_LSB = 0;
    localparam int SIGN_BIT = 35;
    localparam int MAG_MSB = 34;
    localparam int FP_CHR_MSB = 34;
    localparam int FP_CHR_LSB = 27;
    localparam int FP_FRC_MSB = 26;
    // Modifier sub-fields, positions inside the 9-bit modifier
    localparam int MOD_IND_BIT = 8;
    localparam int MOD_SUB_BIT = 7;
    localparam int MOD_IDX_MSB = 2;
    localparam int NUM_IDX = 7;
    // ----------------------------------------------------------------
    // Codes and reset values
    // ----------------------------------------------------------------
    localparam logic [11:0] OPC_ADD = 12'h040;
    localparam logic [35:0] WORD_RST = 36'h0;
    localparam logic [14:0] ADR_RST = 15'h0;
    localparam logic [2:0] IDX_NONE = 3'h0;

    typedef enum logic [2:0] {
        IFAG_IDLE,
        IFAG_IFETCH,
        IFAG_INDIR,
        IFAG_OPER
    } ifag_state_e;
endpackage

// file: logic/ifag_ea_adder.sv
`timescale 1ns/1ps
module ifag_ea_adder
    import ifag_pkg::*;
(
    input wire logic [ADR_W-1:0] base, // Address field of the word
    input wire logic [ADR_W-1:0] index, // Selected index contents
    input wire logic sub, // Subtract index instead of add
    output logic [ADR_W-1:0] ea // Effective address
);
    // Zero index leaves base untouched for both add and subtract
    always_comb begin
        if (index == ADR_RST) begin
            ea = base;
        end else if (sub) begin
            ea = base - index;
        end else begin
            ea = base + index;
        end
    end
endmodule

// file: logic/ifag_core.sv
`timescale 1ns/1ps
module ifag_core
    import ifag_pkg::*;
(
    input wire logic core_clk, // Processor clock, 20 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic start, // Pulse: begin one instruction
    input wire logic [ADR_W-1:0] fetch_addr, // Instruction location
    input wire logic [WORD_W-1:0] acc_in, // Accumulator contents
    input wire logic idx_wr, // Pulse: load an index register
    input wire logic [2:0] idx_sel, // Index register to load, 1..7
    input wire logic [ADR_W-1:0] idx_data, // Value to load
    output logic mem_req, // Storage read request, level
    output logic [ADR_W-1:0] mem_addr, // Storage read address
    input wire logic mem_ack, // Pulse: read word valid
    input wire logic [WORD_W-1:0] mem_rdata, // Word read from storage
    output logic busy, // Instruction in progress
    output logic done, // Pulse: results valid
    output logic [11:0] opcode, // Decoded operation code
    output logic [8:0] modifier, // Decoded modifier field
    output logic [ADR_W-1:0] base_addr, // Decoded address field
    output logic [ADR_W-1:0] eff_addr, // Final operand location
    output logic [WORD_W-1:0] operand, // Operand word
    output logic fp_sign, // Floating sign
    output logic [7:0] fp_char, // Floating characteristic
    output logic [26:0] fp_frac, // Floating fraction
    output logic [WORD_W-1:0] acc_sum, // Add result, sign-magnitude
    output logic acc_ovf // Add magnitude overflow
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ifag_state_e st;
        logic busy;
        logic done;
        logic mem_req;
        logic [ADR_W-1:0] mem_addr;
        logic [11:0] opcode;
        logic [8:0] modifier;
        logic [ADR_W-1:0] base_addr;
        logic [ADR_W-1:0] eff_addr;
        logic [WORD_W-1:0] operand;
        logic fp_sign;
        logic [7:0] fp_char;
        logic [26:0] fp_frac;
        logic [WORD_W-1:0] acc_sum;
        logic acc_ovf;
        logic [NUM_IDX-1:0][ADR_W-1:0] idx;
    } ifag_regs_s;

    ifag_regs_s r;
    ifag_regs_s next_r;

    // ----------------------------------------------------------------
    // Index lookup and address arithmetic on the word being returned
    // ----------------------------------------------------------------
    logic [11:0] rd_op;
    logic [8:0] rd_mod;
    logic [ADR_W-1:0] rd_base;
    logic [2:0] rd_sel;
    logic [NUM_IDX-1:0] idx_load;
    logic [NUM_IDX-1:0][ADR_W-1:0] rd_pick;
    logic [ADR_W-1:0] rd_index;
    logic [ADR_W-1:0] rd_ea;

    assign rd_op = mem_rdata[OP_MSB:OP_LSB];
    assign rd_mod = mem_rdata[MOD_MSB:MOD_LSB];
    assign rd_base = mem_rdata[ADR_MSB:ADR_LSB];
    assign rd_sel = rd_mod[MOD_IDX_MSB:0];

    // Per register: load strobe, and a copy masked by the read select
    for (genvar g = 0; g < NUM_IDX; g++) begin : g_idx
        assign idx_load[g] = idx_wr && (idx_sel == 3'(g + 1));
        assign rd_pick[g] = (rd_sel == 3'(g + 1)) ? r.idx[g] : ADR_RST;
    end

    // Select code zero hits no register, so the index reads as zero
    always_comb begin
        rd_index = ADR_RST;
        for (int k = 0; k < NUM_IDX; k++) begin
            rd_index = rd_index | rd_pick[k];
        end
    end

    ifag_ea_adder u_adder (
        .base(rd_base),
        .index(rd_index),
        .sub(rd_mod[MOD_SUB_BIT]),
        .ea(rd_ea)
    );

    // ----------------------------------------------------------------
    // Sign-magnitude add of operand and accumulator
    // ----------------------------------------------------------------
    function automatic logic [WORD_W:0] sm_add(
        input logic [WORD_W-1:0] a,
        input logic [WORD_W-1:0] b
    );
        logic [MAG_MSB+1:0] sum;
        logic [MAG_MSB:0] ma;
        logic [MAG_MSB:0] mb;
        ma = a[MAG_MSB:0];
        mb = b[MAG_MSB:0];
        sum = {1'b0, ma} + {1'b0, mb};
        if (a[SIGN_BIT] == b[SIGN_BIT]) begin
            sm_add = {sum[MAG_MSB+1], a[SIGN_BIT], sum[MAG_MSB:0]};
        end else if (ma >= mb) begin
            sm_add = {1'b0, a[SIGN_BIT], ma - mb};
        end else begin
            sm_add = {1'b0, b[SIGN_BIT], mb - ma};
        end
    endfunction

    logic [WORD_W:0] add_res;

    assign add_res = sm_add(mem_rdata, acc_in);

    // ----------------------------------------------------------------
    // Floating fields of the word being returned
    // ----------------------------------------------------------------
    logic rd_fp_sign;
    logic [7:0] rd_fp_char;
    logic [26:0] rd_fp_frac;

    assign rd_fp_sign = mem_rdata[SIGN_BIT];
    assign rd_fp_char = mem_rdata[FP_CHR_MSB:FP_CHR_LSB];
    assign rd_fp_frac = mem_rdata[FP_FRC_MSB:0];

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        for (int k = 0; k < NUM_IDX; k++) begin
            if (idx_load[k]) begin
                next_r.idx[k] = idx_data;
            end
        end
        case (r.st)
            IFAG_IDLE: begin
                // Start is looked at only here, so one given while busy is lost
                if (start) begin
                    next_r.busy = 1'b1;
                    next_r.mem_req = 1'b1;
                    next_r.mem_addr = fetch_addr;
                    next_r.st = IFAG_IFETCH;
                end
            end
            IFAG_IFETCH: begin
                if (mem_ack) begin
                    // Instruction time: word is decoded whatever it holds
                    next_r.opcode = rd_op;
                    next_r.modifier = rd_mod;
                    next_r.base_addr = rd_base;
                    next_r.eff_addr = rd_ea;
                    next_r.mem_addr = rd_ea;
                    if (rd_mod[MOD_IND_BIT]) begin
                        next_r.st = IFAG_INDIR;
                    end else begin
                        next_r.st = IFAG_OPER;
                    end
                end
            end
            IFAG_INDIR: begin
                if (mem_ack) begin
                    // Only address, index and subtract fields of the indirect word count
                    next_r.eff_addr = rd_ea;
                    next_r.mem_addr = rd_ea;
                    next_r.st = IFAG_OPER;
                end
            end
            IFAG_OPER: begin
                if (mem_ack) begin
                    // Execution time: the word is data whatever it holds
                    next_r.operand = mem_rdata;
                    next_r.fp_sign = rd_fp_sign;
                    next_r.fp_char = rd_fp_char;
                    next_r.fp_frac = rd_fp_frac;
                    if (r.opcode == OPC_ADD) begin
                        next_r.acc_sum = add_res[WORD_W-1:0];
                        next_r.acc_ovf = add_res[WORD_W];
                    end
                    next_r.mem_req = 1'b0;
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                    next_r.st = IFAG_IDLE;
                end
            end
            default: begin
                next_r.st = IFAG_IDLE;
                next_r.mem_req = 1'b0;
                next_r.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign mem_req = r.mem_req;
    assign mem_addr = r.mem_addr;
    assign busy = r.busy;
    assign done = r.done;
    assign opcode = r.opcode;
    assign modifier = r.modifier;
    assign base_addr = r.base_addr;
    assign eff_addr = r.eff_addr;
    assign operand = r.operand;
    assign fp_sign = r.fp_sign;
    assign fp_char = r.fp_char;
    assign fp_frac = r.fp_frac;
    assign acc_sum = r.acc_sum;
    assign acc_ovf = r.acc_ovf;
endmodule

// file: testbench/ifag_core_chk.sv
`timescale 1ns/1ps
module ifag_core_chk
    import ifag_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic start, // Begin
    input wire logic busy, // Running
    input wire logic done, // Finished
    input wire logic mem_req, // Request
    input wire logic mem_ack, // Answer
    input wire logic [ADR_W-1:0] mem_addr, // Address
    input wire logic [WORD_W-1:0] mem_rdata, // Word read
    input wire logic [11:0] opcode, // Opcode
    input wire logic [ADR_W-1:0] base_addr, // Address field
    input wire logic [ADR_W-1:0] eff_addr, // Final address
    input wire logic [WORD_W-1:0] operand, // Operand
    input wire logic [7:0] fp_char // Characteristic
);
    logic [1:0] ack_n;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------
    // Accesses since the last launch
    // ------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_n <= 2'h0;
        end else if (start && !busy) begin
            ack_n <= 2'h0;
        end else if (mem_req && mem_ack) begin
            ack_n <= ack_n + 2'h1;
        end
    end
    sequence s_take;
        mem_req && mem_ack;
    endsequence
    sequence s_ifetch;
        s_take ##0 ack_n == 2'h0;
    endsequence
    chk_first_fetch: assert property (
        start && !busy |=> mem_req && busy)
        else $error("no fetch after start");
    chk_addr_hold: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("request address moved");
    chk_field_split: assert property (
        s_ifetch |=> opcode == $past(mem_rdata[OP_MSB:OP_LSB])
        && base_addr == $past(mem_rdata[ADR_MSB:ADR_LSB]))
        else $error("fields wrong");
    chk_ea_issue: assert property (
        s_ifetch |=> mem_req && mem_addr == eff_addr)
        else $error("next access not at effective address");
    chk_done_cause: assert property (
        done |-> $past(mem_req && mem_ack) && !busy && !mem_req)
        else $error("done without operand answer");
    chk_operand_word: assert property (
        done |-> operand == $past(mem_rdata) && eff_addr == $past(mem_addr))
        else $error("operand not the word read");
    chk_fp_char: assert property (
        done |-> fp_char == $past(mem_rdata[FP_CHR_MSB:FP_CHR_LSB]))
        else $error("characteristic wrong");
    chk_busy_end: assert property (
        $fell(busy) |-> done)
        else $error("busy fell without done");
    chk_access_count: assert property (
        s_take |-> ack_n <= 2'h2)
        else $error("too many accesses");
endmodule

// file: testbench/ifag_store.sv
`timescale 1ns/1ps
module ifag_store
    import ifag_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic [2:0] lat, // Wait cycles
    input wire logic mem_req, // Request
    input wire logic [ADR_W-1:0] mem_addr, // Address
    output logic mem_ack, // Answer
    output logic [WORD_W-1:0] mem_rdata // Word read
);
    logic [WORD_W-1:0] mem [2**ADR_W];
    logic [2:0] wait_n;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'h0;
            wait_n <= 3'h0;
            mem_rdata <= 36'h0;
        end else if (mem_req && !mem_ack && wait_n >= lat) begin
            mem_ack <= 1'h1;
            mem_rdata <= mem[mem_addr];
            wait_n <= 3'h0;
        end else begin
            // Word is not held outside the answer cycle
            mem_ack <= 1'h0;
            mem_rdata <= ~mem_rdata;
            wait_n <= (mem_req && !mem_ack) ? wait_n + 3'h1 : 3'h0;
        end
    end
endmodule

// file: testbench/ifag_core_tb.sv
`timescale 1ns/1ps
module ifag_core_tb;
    import ifag_pkg::*;
    typedef struct packed {
        logic [35:0] ins;
        logic [14:0] ea;
        logic [35:0] opd;
        logic [36:0] sum;
    } ifag_exp_s;
    logic core_clk = 1'h0, rst_n = 1'h0, start = 1'h0, idx_wr = 1'h0;
    logic [2:0] idx_sel = 3'h0, lat = 3'h0;
    logic [14:0] fetch_addr = 15'h0, idx_data = 15'h0, mem_addr;
    logic [14:0] base_addr, eff_addr, xr [8];
    logic [35:0] acc_in = 36'h0, mem_rdata, operand, acc_sum;
    logic mem_req, mem_ack, busy, done, fp_sign, acc_ovf;
    logic [11:0] opcode;
    logic [8:0] modifier;
    logic [7:0] fp_char;
    logic [26:0] fp_frac;
    logic [36:0] last_sum = 37'h0;
    ifag_exp_s q [$];
    ifag_exp_s e;
    int miscompares = 0, cmp_count = 0;
    always #25 core_clk = ~core_clk;
    ifag_core i_dut (.core_clk, .rst_n, .start, .fetch_addr, .acc_in, .idx_wr,
        .idx_sel, .idx_data, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .busy,
        .done, .opcode, .modifier, .base_addr, .eff_addr, .operand, .fp_sign,
        .fp_char, .fp_frac, .acc_sum, .acc_ovf);
    ifag_store i_mem (.core_clk, .rst_n, .lat, .mem_req, .mem_addr, .mem_ack,
        .mem_rdata);
    // ----------------
    // Reference models
    // ----------------
    function automatic logic [35:0] rnd36();
        return 36'({$urandom(), $urandom()});
    endfunction
    function automatic logic [14:0] ea_of(input logic [35:0] w);
        return w[22] ? w[14:0] - xr[w[17:15]] : w[14:0] + xr[w[17:15]];
    endfunction
    function automatic logic [36:0] sm_add(input logic [35:0] a, b);
        logic [35:0] m;
        m = {1'h0, a[34:0]} + {1'h0, b[34:0]};
        if (a[35] == b[35]) return {m[35], a[35], m[34:0]};
        if (a[34:0] >= b[34:0]) return {1'h0, a[35], a[34:0] - b[34:0]};
        return {1'h0, b[35], b[34:0] - a[34:0]};
    endfunction
    task automatic cmp_word(input logic [36:0] got, input logic [36:0] exp);
        cmp_count++;
        if (got !== exp || $isunknown(got)) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr_idx(input logic [2:0] s, input logic [14:0] v);
        idx_sel <= s;
        idx_data <= v;
        idx_wr <= 1'h1;
        if (s != 3'h0) xr[s] = v;
        @(posedge core_clk);
    endtask
    task automatic run_one(input logic [14:0] fa);
        logic [35:0] w, a;
        logic [14:0] r, r1;
        w = rnd36();
        if ($urandom_range(1)) w[35:24] = OPC_ADD;
        i_mem.mem[fa] = w;
        r = ea_of(w);
        r1 = r;
        if (w[23]) begin
            if (r != fa) i_mem.mem[r] = rnd36();
            r = ea_of(i_mem.mem[r]);
        end
        if (r != fa && !(w[23] && r == r1)) i_mem.mem[r] = rnd36();
        a = rnd36();
        if (w[35:24] == OPC_ADD) last_sum = sm_add(i_mem.mem[r], a);
        q.push_back('{w, r, i_mem.mem[r], last_sum});
        lat <= 3'($urandom_range(3));
        fetch_addr <= fa;
        acc_in <= a;
        start <= 1'h1;
        @(posedge core_clk);
        if ($urandom_range(1)) @(posedge core_clk);
        start <= 1'h0;
        for (int i = 0; i < 60 && done !== 1'h1; i++) @(posedge core_clk);
        if (done !== 1'h1) begin
            miscompares++;
            $display("Error at %0t: no done after start", $time);
        end
    endtask
    // ----------------
    // Result monitor
    // ----------------
    always @(posedge core_clk) begin
        if (done === 1'h1 && q.size() == 0) begin
            miscompares++;
            $display("Error at %0t: result with no expectation", $time);
        end else if (done === 1'h1) begin
            e = q.pop_front();
            cmp_word({28'h0, modifier}, {28'h0, e.ins[23:15]});
            cmp_word({25'h0, opcode}, {25'h0, e.ins[35:24]});
            cmp_word({22'h0, base_addr}, {22'h0, e.ins[14:0]});
            cmp_word({1'h0, fp_sign, fp_char, fp_frac}, {1'h0, e.opd});
            cmp_word({22'h0, eff_addr}, {22'h0, e.ea});
            cmp_word({1'h0, operand}, {1'h0, e.opd});
            cmp_word({acc_ovf, acc_sum}, e.sum);
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        wrap_up;
    end
    initial begin
        void'($urandom(90480));
        foreach (xr[i]) xr[i] = 15'h0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        for (int i = 0; i < 8; i++) wr_idx(3'(i), i == 5 ? 15'h0 : 15'($urandom()));
        idx_wr <= 1'h0;
        for (int i = 0; i < 80; i++) begin
            if (i == 40) wr_idx(3'h3, 15'h7fff);
            idx_wr <= 1'h0;
            run_one(15'($urandom()));
        end
        repeat (3) @(posedge core_clk);
        if (q.size() != 0) begin
            miscompares++;
            $display("Error at %0t: expectations left unmatched", $time);
        end
        wrap_up;
    end
endmodule
bind ifag_core ifag_core_chk i_chk (.core_clk, .rst_n, .start, .busy, .done,
    .mem_req, .mem_ack, .mem_addr, .mem_rdata, .opcode, .base_addr,
    .eff_addr, .operand, .fp_char);
